// File: rtl/pdt_timer.v
/*
 * Prescaled down timer: live count, control, interrupt clear, raw and gated status,
 * primary and deferred reload registers, and a level interrupt output.
 * Assumes a one-cycle strobe register port with read data one cycle after the read.
 */
`default_nettype none
`include "pdt_consts.vh"

module pdt_timer (
  // Clock, reset and clock enable.
  input wire core_clk_i,
  input wire reset_n_i,
  input wire clk_en_i,
  // Register port.
  input wire [5:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // Interrupt line.
  output reg irq_o
);
  reg [7:0] ctrl_r;
  reg [31:0] live_count_r;
  reg [31:0] live_count_nxt;
  reg unmasked_irq_flag_r;
  reg halted_r;
  reg halted_nxt;
  reg hit_zero;
  reg [31:0] rdata_nxt;
  wire [31:0] reload_value;
  wire tick;
  wire wr_primary;
  wire wr_defer;
  wire wr_ctrl;
  wire wr_iclr;
  wire running;
  wire wide;
  wire [31:0] width_max;
  wire [31:0] width_mask;
  wire gated_irq_flag;

  assign wr_primary = reg_wr_i && (reg_addr_i == `PDT_OFF_PRIMARY);
  assign wr_defer = reg_wr_i && (reg_addr_i == `PDT_OFF_DEFER);
  assign wr_ctrl = reg_wr_i && (reg_addr_i == `PDT_OFF_CTRL);
  assign wr_iclr = reg_wr_i && (reg_addr_i == `PDT_OFF_ICLR);

  assign running = ctrl_r[`PDT_CTRL_EN] && !halted_r;
  assign wide = ctrl_r[`PDT_CTRL_WIDE];
  assign width_max = wide ? 32'hffffffff : 32'h0000ffff;
  assign width_mask = width_max;

  pdt_reload_store u_store (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .wr_i(wr_primary || wr_defer),
    .wdata_i(reg_wdata_i),
    .value_o(reload_value)
  );

  pdt_prescaler u_pre (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .run_i(running),
    .restart_i(wr_primary),
    .mode_i(ctrl_r[`PDT_CTRL_PRE_HI:`PDT_CTRL_PRE_LO]),
    .tick_o(tick)
  );

  // In 16-bit mode only the low half counts; every load and tick zero the upper half, so
  // after the first of them the readback shows the effective count.
  always @* begin
    live_count_nxt = live_count_r;
    halted_nxt = halted_r;
    hit_zero = 1'b0;
    if (wr_primary) begin
      live_count_nxt = reload_value_in(reg_wdata_i, width_mask);
      halted_nxt = 1'b0;
    end else if (running && tick) begin
      if ((live_count_r & width_mask) == 32'h00000001) begin
        live_count_nxt = 32'h00000000;
        hit_zero = 1'b1;
        if (ctrl_r[`PDT_CTRL_ONESHOT]) begin
          halted_nxt = 1'b1;
        end
      end else if ((live_count_r & width_mask) == 32'h00000000) begin
        if (ctrl_r[`PDT_CTRL_PERIODIC]) begin
          live_count_nxt = reload_value & width_mask;
        end else begin
          live_count_nxt = width_max;
        end
      end else begin
        live_count_nxt = (live_count_r - 32'h00000001) & width_mask;
      end
    end
  end

  function [31:0] reload_value_in;
    input [31:0] value;
    input [31:0] mask;
    begin
      reload_value_in = value & mask;
    end
  endfunction

  assign gated_irq_flag = unmasked_irq_flag_r && ctrl_r[`PDT_CTRL_IE];

  always @* begin
    case (reg_addr_i)
      `PDT_OFF_PRIMARY: rdata_nxt = reload_value;
      `PDT_OFF_DEFER: rdata_nxt = reload_value;
      `PDT_OFF_COUNT: rdata_nxt = live_count_r;
      `PDT_OFF_CTRL: rdata_nxt = {24'h000000, ctrl_r};
      `PDT_OFF_RAW: rdata_nxt = {31'h00000000, unmasked_irq_flag_r};
      `PDT_OFF_GATED: rdata_nxt = {31'h00000000, gated_irq_flag};
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_r <= `PDT_CTRL_RESET;
      live_count_r <= `PDT_COUNT_RESET;
      halted_r <= 1'b0;
      unmasked_irq_flag_r <= 1'b0;
      irq_o <= 1'b0;
      reg_rdata_o <= 32'h00000000;
    end else if (clk_en_i) begin
      live_count_r <= live_count_nxt;
      halted_r <= halted_nxt;
      if (wr_ctrl) begin
        // Bit 4 is read-only zero.
        ctrl_r <= reg_wdata_i[7:0] & 8'hef;
      end
      // A zero hit in the same cycle as a clear keeps the flag set.
      if (hit_zero) begin
        unmasked_irq_flag_r <= 1'b1;
      end else if (wr_iclr) begin
        unmasked_irq_flag_r <= 1'b0;
      end
      // The line is registered from next-state values so it matches gated status.
      irq_o <= (hit_zero || (unmasked_irq_flag_r && !wr_iclr)) &&
               (wr_ctrl ? reg_wdata_i[`PDT_CTRL_IE] : ctrl_r[`PDT_CTRL_IE]);
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_nxt;
      end else begin
        reg_rdata_o <= 32'h00000000;
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/pdt_consts.vh
/*
 * Register map, control field positions, reset values and prescale counts for the
 * prescaled down timer.
 * Assumes a word-wide register port with byte offsets as listed here.
 */
`ifndef PDT_CONSTS_VH
`define PDT_CONSTS_VH

`define PDT_OFF_PRIMARY 6'h20
`define PDT_OFF_COUNT 6'h24
`define PDT_OFF_CTRL 6'h28
`define PDT_OFF_ICLR 6'h2c
`define PDT_OFF_RAW 6'h30
`define PDT_OFF_GATED 6'h34
`define PDT_OFF_DEFER 6'h38

`define PDT_CTRL_EN 7
`define PDT_CTRL_PERIODIC 6
`define PDT_CTRL_IE 5
`define PDT_CTRL_PRE_HI 3
`define PDT_CTRL_PRE_LO 2
`define PDT_CTRL_WIDE 1
`define PDT_CTRL_ONESHOT 0

`define PDT_CTRL_RESET 8'h20
`define PDT_COUNT_RESET 32'hffffffff
`define PDT_RELOAD_RESET 32'h00000000

`define PDT_PRE_DIV1 2'h0
`define PDT_PRE_DIV16 2'h1
`define PDT_DIV16_LAST 8'h0f
`define PDT_DIV256_LAST 8'hff

`endif

// File: rtl/pdt_prescaler.v
/*
 * Prescaler that yields one tick every 1, 16 or 256 enabled clocks.
 * Assumes the mode code is stable while running; a restart pulse realigns the phase.
 */
`default_nettype none
`include "pdt_consts.vh"

module pdt_prescaler (
  // Clock and reset.
  input wire core_clk_i,
  input wire reset_n_i,
  input wire clk_en_i,
  // Control.
  input wire run_i,
  input wire restart_i,
  input wire [1:0] mode_i,
  // Tick out.
  output wire tick_o
);
  reg [7:0] phase_r;
  reg [7:0] last;

  always @* begin
    case (mode_i)
      `PDT_PRE_DIV1: last = 8'h00;
      `PDT_PRE_DIV16: last = `PDT_DIV16_LAST;
      default: last = `PDT_DIV256_LAST;
    endcase
  end

  assign tick_o = run_i && (phase_r >= last);

  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_r <= 8'h00;
    end else if (clk_en_i) begin
      if (restart_i || !run_i || tick_o) begin
        phase_r <= 8'h00;
      end else begin
        phase_r <= phase_r + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/pdt_reload_store.v
/*
 * One word of reload storage shared by the primary and deferred reload registers.
 * Assumes a single write port; read data are the stored word itself.
 */
`default_nettype none
`include "pdt_consts.vh"

module pdt_reload_store (
  // Clock and reset.
  input wire core_clk_i,
  input wire reset_n_i,
  input wire clk_en_i,
  // Write side.
  input wire wr_i,
  input wire [31:0] wdata_i,
  // Stored value.
  output reg [31:0] value_o
);
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      value_o <= `PDT_RELOAD_RESET;
    end else if (clk_en_i && wr_i) begin
      value_o <= wdata_i;
    end
  end
endmodule
`default_nettype wire

// File: bench/pdt_timer_sva.sv
/* Assertions on the timer register port and interrupt line.
   Bound to pdt_timer; sees its ports only. */
`default_nettype none
`include "pdt_consts.vh"
module pdt_timer_sva (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // Register port and interrupt.
  input wire logic [5:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rd_ok;
  logic wr_ok;
  logic clr_wr;
  logic ctl_wr;
  assign rd_ok = reg_rd_i & clk_en_i;
  assign wr_ok = reg_wr_i & clk_en_i;
  assign clr_wr = wr_ok && reg_addr_i == `PDT_OFF_ICLR;
  assign ctl_wr = wr_ok && reg_addr_i == `PDT_OFF_CTRL;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  a_rdata_idle: assert property ($past(clk_en_i & !reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  a_raw_upper: assert property ($past(rd_ok && reg_addr_i == `PDT_OFF_RAW) |-> reg_rdata_o[31:1] == 31'h0)
    else $error("raw status upper bits set");
  a_gated_upper: assert property ($past(rd_ok && reg_addr_i == `PDT_OFF_GATED) |-> reg_rdata_o[31:1] == 31'h0)
    else $error("gated status upper bits set");
  a_clear_reads_zero: assert property ($past(rd_ok && reg_addr_i == `PDT_OFF_ICLR) |-> reg_rdata_o == 32'h0)
    else $error("clear register read not zero");
  a_hole_reads_zero: assert property ($past(rd_ok && reg_addr_i == 6'h3c) |-> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_reserved: assert property ($past(rd_ok && reg_addr_i == `PDT_OFF_CTRL) |-> reg_rdata_o[31:8] == 24'h0 && !reg_rdata_o[4])
    else $error("control reserved bits set");
  a_irq_holds: assert property (irq_o && clk_en_i && !wr_ok && !$past(wr_ok) |=> irq_o)
    else $error("interrupt dropped without a write");
  a_irq_fall: assert property ($fell(irq_o) |-> $past(clr_wr) || $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("interrupt fell without clear or mask");
endmodule
`default_nettype wire

// File: bench/tb_pdt_timer.sv
/* Self-checking bench for the prescaled down timer.
   Drives the register port directly; clock enable is held high except for 20 edges in t_freeze. */
`default_nettype none
`include "pdt_consts.vh"
module tb_pdt_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 0;
  logic reset_n_i = 0;
  logic clk_en_i = 1;
  logic [5:0] reg_addr_i = 6'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 0;
  logic reg_rd_i = 0;
  wire [31:0] reg_rdata_o;
  wire irq_o;
  int mismatches = 0;
  int samples_checked = 0;
  int n;
  logic [31:0] v;
  pdt_timer u_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic close_out;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge core_clk_i);
    reg_rd_i <= 1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 0;
    #1 v = reg_rdata_o;
  endtask
  task automatic rc(input string s, input logic [5:0] a, input logic [31:0] e);
    rd(a);
    chk(s, e, v);
  endtask
  // A lost interrupt must not hang the run, so the wait is bounded.
  task automatic wirq;
    n = 0;
    while (irq_o !== 1'b1 && n < 2000) begin
      @(posedge core_clk_i);
      n++;
    end
    if (n == 2000) begin
      mismatches++;
      close_out;
    end
  endtask
  task automatic t_reset;
    rc("count", `PDT_OFF_COUNT, 32'hffffffff);
    rc("ctrl", `PDT_OFF_CTRL, 32'h20);
    rc("raw", `PDT_OFF_RAW, 32'h0);
    rc("gated", `PDT_OFF_GATED, 32'h0);
    rc("defer", `PDT_OFF_DEFER, 32'h0);
    rc("clr", `PDT_OFF_ICLR, 32'h0);
    rc("hole", 6'h3c, 32'h0);
    wr(`PDT_OFF_COUNT, 32'h5);
    rc("count_ro", `PDT_OFF_COUNT, 32'hffffffff);
  endtask
  task automatic t_oneshot;
    wr(`PDT_OFF_CTRL, 32'ha7);
    wr(`PDT_OFF_PRIMARY, 32'h2);
    wirq;
    chk("div16", 1, n >= 24 && n <= 40);
    repeat (40) @(posedge core_clk_i);
    rc("halt", `PDT_OFF_COUNT, 32'h0);
    rc("raw", `PDT_OFF_RAW, 32'h1);
    rc("gated", `PDT_OFF_GATED, 32'h1);
    wr(`PDT_OFF_CTRL, 32'h87);
    rc("masked", `PDT_OFF_GATED, 32'h0);
    chk("irq", 0, irq_o);
    wr(`PDT_OFF_ICLR, 32'h0);
    rc("cleared", `PDT_OFF_RAW, 32'h0);
  endtask
  task automatic t_periodic;
    wr(`PDT_OFF_CTRL, 32'hea);
    wr(`PDT_OFF_PRIMARY, 32'h1);
    wr(`PDT_OFF_DEFER, 32'h5);
    rc("no_restart", `PDT_OFF_COUNT, 32'h1);
    rc("shared", `PDT_OFF_PRIMARY, 32'h5);
    wirq;
    chk("div256", 1, n >= 230 && n <= 260);
    repeat (300) @(posedge core_clk_i);
    rc("reload", `PDT_OFF_COUNT, 32'h5);
    wr(`PDT_OFF_ICLR, 32'h1);
  endtask
  task automatic t_wrap16;
    wr(`PDT_OFF_CTRL, 32'ha0);
    wr(`PDT_OFF_PRIMARY, 32'h3);
    wirq;
    rd(`PDT_OFF_COUNT);
    chk("upper", 0, v[31:16]);
    chk("wrap", 1, v[15:0] > 16'hfff0);
    wr(`PDT_OFF_CTRL, 32'h20);
    rd(`PDT_OFF_COUNT);
    rc("stopped", `PDT_OFF_COUNT, v);
    wr(`PDT_OFF_ICLR, 32'h0);
  endtask
  // The clear write lands on the very edge at which the count reaches zero.
  task automatic t_setwins;
    wr(`PDT_OFF_CTRL, 32'ha3);
    wr(`PDT_OFF_PRIMARY, 32'h3);
    @(posedge core_clk_i);
    wr(`PDT_OFF_ICLR, 32'h0);
    rc("set_wins", `PDT_OFF_RAW, 32'h1);
    chk("set_irq", 1, irq_o);
    wr(`PDT_OFF_ICLR, 32'h0);
    rc("late_clear", `PDT_OFF_RAW, 32'h0);
  endtask
  // With the enable low for 20 edges only the one enabled edge before the read counts.
  task automatic t_freeze;
    wr(`PDT_OFF_CTRL, 32'ha2);
    wr(`PDT_OFF_PRIMARY, 32'h100);
    clk_en_i <= 0;
    repeat (20) @(posedge core_clk_i);
    clk_en_i <= 1;
    rc("frozen", `PDT_OFF_COUNT, 32'hff);
    wr(`PDT_OFF_CTRL, 32'h20);
  endtask
  initial begin
    repeat (10) @(posedge core_clk_i);
    reset_n_i <= 1;
    t_reset;
    t_oneshot;
    t_periodic;
    t_wrap16;
    t_setwins;
    t_freeze;
    close_out;
  end
endmodule
bind pdt_timer pdt_timer_sva u_sva (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
  .clk_en_i(clk_en_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
`default_nettype wire
